/* rtl/eesra_regs.vh */
// Constants for the serial EEPROM read-path addressing block
`ifndef EESRA_REGS_VH
`define EESRA_REGS_VH
`define EESRA_ADDR_W      16
`define EESRA_MEM_LAST    16'hffff
`define EESRA_ADDR_RST    16'h0000
`define EESRA_DEV_CODE    4'ha
`define EESRA_BITS_BYTE   4'h8
`define EESRA_ACK_BIT     4'h8
`endif

/* rtl/eesra_top.v */
// I2C serial EEPROM slave with selective and sequential read addressing
`timescale 1ns/10ps
`include "eesra_regs.vh"
// Operation
// R1: Master selects a location by START, address with write bit, two address bytes.
// R2: Address counter loads from both address bytes of the dummy write.
// R3: Master then sends repeated START and the address with read bit set.
// R4: Acknowledged data byte advances the counter and the next byte follows.
// R5: Counter rolls from last location to first during multi-byte reads.
// R6: Sequential read works after current-address and after selective reads.
// R7: Slave address is 1010, three select-pin bits, then read/write bit.
// R8: Idle counter points one past last accessed byte, wrapping, for current reads.
// R9: Data line released in ninth clock; NoACK then STOP ends the read.
// R10: 16-bit counter spans 65,536 bytes, first address byte is the high byte.
// R11: Dummy write bytes are acknowledged; memory untouched on repeated START.
module eesra_top #(
	parameter AW = `EESRA_ADDR_W
) (
	input  wire          mclk,
	input  wire          nrst,
	input  wire          sclIn,
	input  wire          sdaIn,
	output reg           sdaOut,
	output reg           sdaOe,
	input  wire          device_select_pin_low,
	input  wire          device_select_pin_mid,
	input  wire          device_select_pin_high,
	output reg  [AW-1:0] memAddr,
	input  wire [7:0]    memData,
	output reg  [AW-1:0] addrCounter
);
	localparam ST_IDLE = 3'd0;
	localparam ST_DEV  = 3'd1;
	localparam ST_AHI  = 3'd2;
	localparam ST_ALO  = 3'd3;
	localparam ST_RD   = 3'd4;
	localparam ST_SKIP = 3'd5;

	reg          rstMeta_reg;
	reg          rstSync_reg;
	reg  [2:0]   sclSync_reg;
	reg  [2:0]   sdaSync_reg;
	reg  [2:0]   selMeta_reg;
	reg  [2:0]   selSync_reg;
	reg  [2:0]   state_reg;
	reg  [3:0]   bitCnt_reg;
	reg  [7:0]   shift_reg;
	reg  [7:0]   txByte_reg;
	reg  [7:0]   addrHi_reg;
	reg  [AW-1:0] counter_reg;
	reg          ackPhase_reg;
	reg          readMode_reg;
	wire         rstN;
	wire         sclRise;
	wire         sclFall;
	wire         sclHigh;
	wire         startCond;
	wire         stopCond;
	wire [2:0]   selPins;

	assign rstN = rstSync_reg;
	// Address compare only ever sees the synchronised straps
	assign selPins = selSync_reg;

	// Reset release through two flops
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rstMeta_reg <= 1'b0;
			rstSync_reg <= 1'b0;
		end else begin
			rstMeta_reg <= 1'b1;
			rstSync_reg <= rstMeta_reg;
		end
	end

	// Pin synchronisers; edge logic reads only stages 1 and 2
	always @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			sclSync_reg <= 3'h7;
			sdaSync_reg <= 3'h7;
		end else begin
			sclSync_reg <= {sclSync_reg[1:0], sclIn};
			sdaSync_reg <= {sdaSync_reg[1:0], sdaIn};
		end
	end

	// Select straps come from board pins, so they cross through two flops too
	always @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			selMeta_reg <= 3'h0;
			selSync_reg <= 3'h0;
		end else begin
			selMeta_reg <= {device_select_pin_high, device_select_pin_mid, device_select_pin_low};
			selSync_reg <= selMeta_reg;
		end
	end

	// Edge and condition decode from the settled stages only
	assign sclRise   = sclSync_reg[1] & ~sclSync_reg[2];
	assign sclFall   = ~sclSync_reg[1] & sclSync_reg[2];
	assign sclHigh   = sclSync_reg[1] & sclSync_reg[2];
	assign startCond = sclHigh & ~sdaSync_reg[1] & sdaSync_reg[2];
	assign stopCond  = sclHigh & sdaSync_reg[1] & ~sdaSync_reg[2];

	// Address match on fixed code and select pins
	function match;
		input [6:0] a;
		input [2:0] pins;
		begin
			match = (a[6:3] == `EESRA_DEV_CODE) && (a[2:0] == pins); // R7
		end
	endfunction

	// Protocol engine: bits sampled on SCL rise, driven on SCL fall
	always @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			state_reg    <= ST_IDLE;
			bitCnt_reg   <= 4'h0;
			shift_reg    <= 8'h00;
			txByte_reg   <= 8'hff;
			addrHi_reg   <= 8'h00;
			counter_reg  <= `EESRA_ADDR_RST;
			ackPhase_reg <= 1'b0;
			readMode_reg <= 1'b0;
			sdaOut       <= 1'b1;
			sdaOe        <= 1'b0;
			memAddr      <= `EESRA_ADDR_RST;
			addrCounter  <= `EESRA_ADDR_RST;
		end else begin
			memAddr     <= counter_reg;
			addrCounter <= counter_reg;
			if (startCond) begin
				// Repeated START abandons a dummy write, nothing is written
				state_reg    <= ST_DEV; // R1 R3 R11
				bitCnt_reg   <= 4'h0;
				ackPhase_reg <= 1'b0;
				sdaOe        <= 1'b0;
			end else if (stopCond) begin
				state_reg    <= ST_IDLE; // R9
				sdaOe        <= 1'b0;
				ackPhase_reg <= 1'b0;
			end else if (state_reg != ST_IDLE && state_reg != ST_SKIP) begin
				if (sclRise) begin
					if (ackPhase_reg) begin
						if (state_reg == ST_RD) begin
							// Master ACK low continues, NoACK ends the stream.
							// Both step the counter, so an idle counter always
							// points past the byte last sent, wrapping at the top.
							if (!sdaSync_reg[1]) begin
								counter_reg <= counter_reg + 1'b1; // R4 R5 R8
							end else begin
								counter_reg <= counter_reg + 1'b1; // R8
								state_reg   <= ST_SKIP; // R9
							end
						end
					end else begin
						shift_reg  <= {shift_reg[6:0], sdaSync_reg[1]};
						bitCnt_reg <= bitCnt_reg + 1'b1;
					end
				end else if (sclFall) begin
					if (ackPhase_reg) begin
						// End of ninth clock: next byte or release
						ackPhase_reg <= 1'b0;
						bitCnt_reg   <= 4'h0;
						// Read address ack ends here too; first byte comes from the counter
						if (state_reg == ST_RD || (state_reg == ST_DEV && readMode_reg)) begin
							state_reg  <= ST_RD;
							txByte_reg <= {memData[6:0], 1'b1};
							sdaOut     <= memData[7]; // R6
							sdaOe      <= 1'b1;
						end else begin
							sdaOe <= 1'b0;
						end
					end else if (bitCnt_reg == `EESRA_BITS_BYTE) begin
						ackPhase_reg <= 1'b1;
						case (state_reg)
							ST_DEV: begin
								if (match(shift_reg[7:1], selPins)) begin
									sdaOut       <= 1'b0;
									sdaOe        <= 1'b1;
									readMode_reg <= shift_reg[0];
									// On a read, stay in address state through our own ack,
									// else our low ack would look like a master ACK
									// and bump the counter before the first byte
									state_reg    <= shift_reg[0] ? ST_DEV : ST_AHI;
								end else begin
									state_reg <= ST_SKIP;
									sdaOe     <= 1'b0;
								end
							end
							ST_AHI: begin
								addrHi_reg <= shift_reg; // R10
								sdaOut     <= 1'b0; // R11
								sdaOe      <= 1'b1;
								state_reg  <= ST_ALO;
							end
							ST_ALO: begin
								counter_reg <= {addrHi_reg, shift_reg}; // R2 R10
								sdaOut      <= 1'b0; // R11
								sdaOe       <= 1'b1;
								state_reg   <= ST_SKIP;
							end
							default: begin
								// Release SDA for master acknowledge
								sdaOe <= 1'b0; // R9
							end
						endcase
					end else if (state_reg == ST_RD) begin
						sdaOut     <= txByte_reg[7];
						txByte_reg <= {txByte_reg[6:0], 1'b1};
						sdaOe      <= 1'b1;
					end
				end
			end else if (state_reg == ST_SKIP && sclFall && ackPhase_reg) begin
				// Finish the ack slot after address low byte, then ignore data
				ackPhase_reg <= 1'b0;
				sdaOe        <= 1'b0;
			end
		end
	end
endmodule

/* tb/eesra_props.sv */
// Port checker for the read addressing block
`timescale 1ns/10ps
module eesra_props #(parameter AW = 16) (
	input wire          mclk, nrst, sclIn, sdaOut, sdaOe,
	input wire [AW-1:0] memAddr, addrCounter
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	// Raw scl leads the synchronised copy, so allow three cycles of skew
	oe_edge_a: assert property ($changed(sdaOe) |-> !sclIn || !$past(sclIn, 3)) else $error("oe edge");
	cnt_edge_a: assert property ($changed(addrCounter) |-> !$past(sdaOe, 2)) else $error("cnt edge");
	cnt_copy_a: assert property ($changed(addrCounter) |-> ##[0:2] memAddr == addrCounter) else $error("copy");
	cnt_once_a: assert property ($changed(addrCounter) |=> $stable(addrCounter)[*3]) else $error("step");
	oe_hold_a: assert property ($rose(sdaOe) |=> sdaOe[*3]) else $error("oe hold");
	ack_low_a: assert property (sdaOe && !sdaOut && $rose(sclIn) |-> (sdaOe && !sdaOut)[*3]) else $error("ack");
	bit_hold_a: assert property (sdaOe && sclIn && $past(sclIn, 3) |-> $stable(sdaOut)) else $error("bit");
	rst_idle_a: assert property (disable iff (1'b0) !nrst && !$past(nrst) |-> !sdaOe && addrCounter == 16'h0000) else $error("rst");
	cover property ($changed(addrCounter));
	cover property ($rose(sdaOe));
	cover property (sdaOe && !sdaOut && sclIn);
endmodule
bind eesra_top eesra_props #(.AW(AW)) eesra_props_i (.*);

/* tb/eesra_m.sv */
// Bus master model driving scl and the master side of sda
`timescale 1ns/10ps
module eesra_m (
	output reg  scl,
	output reg  sdaM,
	input  wire sda
);
	initial begin
		scl = 1'h1;
		sdaM = 1'h1;
	end
	// Quarter-period steps of 200 ns keep every change on a falling mclk edge
	task st; begin sdaM = 1'h1; #200 scl = 1'h1; #200 sdaM = 1'h0; #200 scl = 1'h0; #200; end endtask
	task sp; begin sdaM = 1'h0; #200 scl = 1'h1; #200 sdaM = 1'h1; #200; end endtask
	task bw(input b); begin sdaM = b; #200 scl = 1'h1; #400 scl = 1'h0; #200; end endtask
	task br(output b); begin sdaM = 1'h1; #200 scl = 1'h1; #200 b = sda; #200 scl = 1'h0; #200; end endtask
	task wr(input [7:0] d, output ack); integer i; begin for (i = 7; i >= 0; i = i - 1) bw(d[i]); br(ack); end endtask
	task rd(input last, output [7:0] d); integer i; begin for (i = 7; i >= 0; i = i - 1) br(d[i]); bw(last); end endtask
endmodule

/* tb/tb_eesra_top.sv */
// Self-checking bench for the read addressing block
`timescale 1ns/10ps
module tb_eesra_top;
	localparam [71:0] ROWS = {24'h123402, 24'h00ff03, 24'h800001};
	reg         mclk = 1'h0, nrst = 1'h0, ack;
	reg  [2:0]  sel = 3'h5;
	reg  [7:0]  d;
	reg  [15:0] a;
	integer     n_fail = 0, n_checks = 0, r;
	wire        scl, sdaM, sdaOut, sdaOe;
	wire [15:0] memAddr, addrCounter;
	wire        sda = sdaM & (sdaOe ? sdaOut : 1'h1);
	wire [7:0]  memData = f(memAddr);
	function [7:0] f(input [15:0] x); f = x[7:0] ^ x[15:8] ^ 8'h5a; endfunction
	initial forever #50 mclk = ~mclk;
	eesra_top eesra_top_i (.mclk(mclk), .nrst(nrst), .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut),
		.sdaOe(sdaOe), .device_select_pin_low(sel[0]), .device_select_pin_mid(sel[1]),
		.device_select_pin_high(sel[2]), .memAddr(memAddr), .memData(memData),
		.addrCounter(addrCounter));
	eesra_m eesra_m_i (.scl(scl), .sdaM(sdaM), .sda(sda));
	task chk(input [15:0] s, e); begin n_checks = n_checks + 1; if (s !== e) begin
		n_fail = n_fail + 1; $display("BAD %0t %h %h", $time, s, e); end end endtask
	task final_report; begin
		$display("checks %0d fails %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	end endtask
	// Read n bytes, optionally after a dummy write that sets the start
	task rdn(input sa, input [15:0] ad, input [7:0] n); integer i; begin
		if (sa) begin
			eesra_m_i.st;
			eesra_m_i.wr({4'ha, sel, 1'h0}, ack);
			chk({15'h0, ack}, 16'h0);
			eesra_m_i.wr(ad[15:8], ack);
			eesra_m_i.wr(ad[7:0], ack);
			chk({15'h0, ack}, 16'h0);
			a = ad;
		end
		eesra_m_i.st;
		eesra_m_i.wr({4'ha, sel, 1'h1}, ack);
		chk({15'h0, ack}, 16'h0);
		for (i = 1; i <= n; i = i + 1) begin
			eesra_m_i.rd(i == n, d);
			chk({8'h0, d}, {8'h0, f(a)});
			a = a + 16'h1;
		end
		eesra_m_i.sp;
		chk(addrCounter, a);
	end endtask
	initial begin
		repeat (10) @(negedge mclk);
		chk(addrCounter, 16'h0);
		nrst = 1'h1;
		repeat (8) @(negedge mclk);
		for (r = 0; r < 3; r = r + 1)
			rdn(1'h1, ROWS[r*24+8 +: 16], ROWS[r*24 +: 8]);
		// Wrap past the last byte, then carry on without a new address
		rdn(1'h1, 16'hfffe, 8'h3);
		rdn(1'h0, 16'h0, 8'h2);
		// Foreign select pins get no acknowledge and move nothing
		eesra_m_i.st;
		eesra_m_i.wr({4'ha, ~sel, 1'h1}, ack);
		chk({15'h0, ack}, 16'h1);
		eesra_m_i.sp;
		chk(addrCounter, a);
		final_report;
	end
	initial begin #2000000; n_fail = n_fail + 1; final_report; end
endmodule
